//--- shared/rcc_consts.svh
// Register offsets, field positions and reset values of the retimer channel control
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH
`define RCC_OFS_RESET 8'h00
`define RCC_OFS_BOOST_OVR_VAL 8'h03
`define RCC_OFS_OUT_SEL_EN 8'h09
`define RCC_OFS_SM_RESET 8'h0a
`define RCC_OFS_OUT_MUX 8'h1e
`define RCC_OFS_EQ_OVR 8'h2d
`define RCC_OFS_RATE 8'h2f
`define RCC_OFS_ADAPT 8'h31
`define RCC_OFS_FIXED_BOOST 8'h3a
`define RCC_OFS_BOOST_RB 8'h52
`define RCC_OFS_TAP3 8'h73
`define RCC_OFS_TAP4 8'h74
`define RCC_OFS_TAP5 8'h75
`define RCC_BIT_CHAN_RESET 2
`define RCC_BIT_SM_OVR_EN 3
`define RCC_BIT_SM_FORCE 2
`define RCC_BIT_EQ_OVR 3
`define RCC_BIT_OUT_SEL_EN 5
`define RCC_RST_RATE 8'h00
`define RCC_RST_OUT_MUX 8'h20
`define RCC_RST_ADAPT 8'h00
`define RCC_RST_FIXED_BOOST 8'h00
`define RCC_RST_BOOST_OVR 8'h00
`define RCC_RATE_RESET_CODE 4'h0
`define RCC_TAP_RESET 5'h00
`define RCC_DWELL_CYC 16'h0400
`define RCC_VCO_MIN_MHZ 8500
`define RCC_VCO_MAX_MHZ 11300
`endif

//--- shared/rcc_pkg.sv
// Types of the retimer channel control
package rcc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rcc_req_t;
  typedef struct packed {
    logic [3:0] ratios;
    logic [15:0] vco_mhz;
  } rcc_grp_t;
  typedef enum logic [4:0] {
    ST_RESET = 5'b0_0001,
    ST_IDLE = 5'b0_0010,
    ST_SEARCH = 5'b0_0100,
    ST_ADAPT = 5'b0_1000,
    ST_LOCKED = 5'b1_0000
  } rcc_state_t;
  typedef enum logic [1:0] {
    OUT_MUTE = 2'h0,
    OUT_RAW = 2'h1,
    OUT_RETIMED = 2'h2
  } rcc_out_t;
endpackage

//--- verilog/rcc_channel.sv
// Channel control of one retimer lane: registers, CDR sequencer, equalizer and output select
`timescale 1ns/1ps
`include "rcc_consts.svh"
module rcc_channel (
  input wire logic mclk,
  input wire logic sys_rst,
  // Register access
  input wire rcc_pkg::rcc_req_t req,
  output logic [7:0] rdata_ff,
  output logic rvalid_ff,
  // Analog status and results
  input wire logic sig_det,
  input wire logic phase_lock,
  input wire logic adapt_done,
  input wire logic [3:0] adapt_boost,
  input wire logic [14:0] tap_res,
  input wire logic tap_valid,
  // Analog controls
  output logic cdr_rst_ff,
  output logic adapt_en_ff,
  output logic [1:0] adapt_mode_ff,
  output logic [1:0] div_sel_ff,
  output logic [15:0] vco_mhz_ff,
  output logic [3:0] boost_ff,
  output rcc_pkg::rcc_out_t out_sel_ff,
  output logic drv_pwr_ff
);
  import rcc_pkg::*;

  logic [7:0] reg_boost_ovr_ff, reg_out_en_ff, reg_sm_ff, reg_mux_ff;
  logic [7:0] reg_eq_ovr_ff, reg_rate_ff, reg_adapt_ff, reg_fixed_ff;
  logic [4:0] tap_ff [3];
  rcc_state_t state_ff;
  logic [1:0] rate_idx_ff;
  logic [15:0] dwell_ff;
  logic chan_rst;
  logic sm_hold;
  rcc_grp_t grp0, grp1;
  logic [1:0] cur_div;
  logic [3:0] cur_ratios;
  logic [3:0] nxt_boost;

  // Table of ratio groups per rate code
  function automatic rcc_grp_t grp_lookup(input logic [3:0] code, input logic g1);
    rcc_grp_t r;
    r = '{ratios: 4'h1, vco_mhz: 16'd10313};
    case (code)
      4'h0, 4'hf: r = g1 ? rcc_grp_t'{4'h1, 16'd10313} : rcc_grp_t'{4'h8, 16'd10000};
      4'h1: r = g1 ? rcc_grp_t'{4'h1, 16'd10519} : rcc_grp_t'{4'h7, 16'd8500};
      4'h2: r = '{4'h7, 16'd10000};
      4'h3: r = '{4'h7, 16'd9830};
      4'h4: r = '{4'h6, 16'd12288};
      4'h5: r = '{4'h5, 16'd9953};
      4'h6: r = '{4'hf, 16'd12000};
      4'h7: r = '{4'h1, 16'd8250};
      4'h8: r = '{4'h1, 16'd8500};
      4'h9: r = '{4'h1, 16'd11500};
      4'ha: r = '{4'h2, 16'd12500};
      4'hb: r = '{4'h6, 16'd12500};
      4'hc: r = '{4'h1, 16'd10313};
      4'hd: r = '{4'h1, 16'd9953};
      4'he: r = '{4'h1, 16'd7500};
      default: r = '{4'h1, 16'd10313};
    endcase
    return r;
  endfunction

  // Clamp oscillator to allowed span
  function automatic logic [15:0] vco_clamp(input logic [15:0] f);
    if (f < 16'(`RCC_VCO_MIN_MHZ)) begin
      return 16'(`RCC_VCO_MIN_MHZ);
    end else if (f > 16'(`RCC_VCO_MAX_MHZ)) begin
      return 16'(`RCC_VCO_MAX_MHZ);
    end
    return f;
  endfunction

  assign chan_rst = req.wr && req.addr == `RCC_OFS_RESET &&
    req.wdata[`RCC_BIT_CHAN_RESET];
  assign sm_hold = reg_sm_ff[`RCC_BIT_SM_OVR_EN] && reg_sm_ff[`RCC_BIT_SM_FORCE];
  assign grp0 = grp_lookup(reg_rate_ff[7:4], 1'b0);
  assign grp1 = grp_lookup(reg_rate_ff[7:4], 1'b1);
  assign cur_div = rate_idx_ff;
  assign cur_ratios = grp0.ratios | grp1.ratios;

  // Writable registers; channel reset restores all defaults
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_boost_ovr_ff <= `RCC_RST_BOOST_OVR;
      reg_out_en_ff <= 8'h00;
      reg_sm_ff <= 8'h00;
      reg_mux_ff <= `RCC_RST_OUT_MUX;
      reg_eq_ovr_ff <= 8'h00;
      reg_rate_ff <= `RCC_RST_RATE;
      reg_adapt_ff <= `RCC_RST_ADAPT;
      reg_fixed_ff <= `RCC_RST_FIXED_BOOST;
    end else if (chan_rst) begin
      reg_boost_ovr_ff <= `RCC_RST_BOOST_OVR;
      reg_out_en_ff <= 8'h00;
      reg_sm_ff <= 8'h00;
      reg_mux_ff <= `RCC_RST_OUT_MUX;
      reg_eq_ovr_ff <= 8'h00;
      reg_rate_ff <= `RCC_RST_RATE;
      reg_adapt_ff <= `RCC_RST_ADAPT;
      reg_fixed_ff <= `RCC_RST_FIXED_BOOST;
    end else if (req.wr) begin
      case (req.addr)
        `RCC_OFS_BOOST_OVR_VAL: reg_boost_ovr_ff <= req.wdata;
        `RCC_OFS_OUT_SEL_EN: reg_out_en_ff <= req.wdata;
        `RCC_OFS_SM_RESET: reg_sm_ff <= req.wdata;
        `RCC_OFS_OUT_MUX: reg_mux_ff <= req.wdata;
        `RCC_OFS_EQ_OVR: reg_eq_ovr_ff <= req.wdata;
        `RCC_OFS_RATE: reg_rate_ff <= req.wdata;
        `RCC_OFS_ADAPT: reg_adapt_ff <= req.wdata;
        `RCC_OFS_FIXED_BOOST: reg_fixed_ff <= req.wdata;
        default: ;
      endcase
    end
  end

  // Tap readback captured from the adaptation engine
  generate
    for (genvar i = 0; i < 3; i++) begin : g_tap
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          tap_ff[i] <= `RCC_TAP_RESET;
        end else if (chan_rst) begin
          tap_ff[i] <= `RCC_TAP_RESET;
        end else if (tap_valid) begin
          tap_ff[i] <= tap_res[i*5 +: 5];
        end
      end
    end
  endgenerate

  // Read path; chan reset bit always reads zero
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= req.rd;
      case (req.addr)
        `RCC_OFS_BOOST_OVR_VAL: rdata_ff <= reg_boost_ovr_ff;
        `RCC_OFS_OUT_SEL_EN: rdata_ff <= reg_out_en_ff;
        `RCC_OFS_SM_RESET: rdata_ff <= reg_sm_ff;
        `RCC_OFS_OUT_MUX: rdata_ff <= reg_mux_ff;
        `RCC_OFS_EQ_OVR: rdata_ff <= reg_eq_ovr_ff;
        `RCC_OFS_RATE: rdata_ff <= reg_rate_ff;
        `RCC_OFS_ADAPT: rdata_ff <= reg_adapt_ff;
        `RCC_OFS_FIXED_BOOST: rdata_ff <= reg_fixed_ff;
        `RCC_OFS_BOOST_RB: rdata_ff <= {4'h0, boost_ff};
        `RCC_OFS_TAP3: rdata_ff <= {3'h0, tap_ff[0]};
        `RCC_OFS_TAP4: rdata_ff <= {3'h0, tap_ff[1]};
        `RCC_OFS_TAP5: rdata_ff <= {3'h0, tap_ff[2]};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // CDR sequencer: search rates, lock, adapt
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_RESET;
      rate_idx_ff <= 2'h0;
      dwell_ff <= 16'h0000;
    end else if (sm_hold || chan_rst) begin
      state_ff <= ST_RESET;
      rate_idx_ff <= 2'h0;
      dwell_ff <= 16'h0000;
    end else begin
      case (state_ff)
        ST_RESET: state_ff <= ST_IDLE;
        ST_IDLE: begin
          if (sig_det) begin
            state_ff <= ST_SEARCH;
          end
        end
        ST_SEARCH: begin
          if (!sig_det) begin
            state_ff <= ST_IDLE;
          end else if (phase_lock && cur_ratios[rate_idx_ff]) begin
            state_ff <= ST_ADAPT;
          end else if (dwell_ff == `RCC_DWELL_CYC || !cur_ratios[rate_idx_ff]) begin
            dwell_ff <= 16'h0000;
            rate_idx_ff <= rate_idx_ff + 2'h1;
          end else begin
            dwell_ff <= dwell_ff + 16'h0001;
          end
        end
        ST_ADAPT: begin
          if (!sig_det || !phase_lock) begin
            state_ff <= ST_IDLE;
          end else if (adapt_done || rate_idx_ff >= 2'h2) begin
            state_ff <= ST_LOCKED;
          end
        end
        ST_LOCKED: begin
          if (!sig_det || !phase_lock) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_RESET;
      endcase
    end
  end

  // Boost selection
  always_comb begin
    if (reg_eq_ovr_ff[`RCC_BIT_EQ_OVR]) begin
      nxt_boost = reg_boost_ovr_ff[3:0];
    end else if (cur_div >= 2'h2) begin
      nxt_boost = reg_fixed_ff[3:0];
    end else begin
      nxt_boost = adapt_boost;
    end
  end

  // Analog control outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cdr_rst_ff <= 1'b1;
      adapt_en_ff <= 1'b0;
      adapt_mode_ff <= 2'h0;
      div_sel_ff <= 2'h0;
      vco_mhz_ff <= 16'h0000;
      boost_ff <= 4'h0;
      out_sel_ff <= OUT_MUTE;
      drv_pwr_ff <= 1'b0;
    end else begin
      cdr_rst_ff <= state_ff == ST_RESET;
      adapt_en_ff <= state_ff == ST_ADAPT && cur_div < 2'h2;
      adapt_mode_ff <= reg_adapt_ff[6:5];
      div_sel_ff <= cur_div;
      vco_mhz_ff <= vco_clamp(grp1.ratios[cur_div] ? grp1.vco_mhz : grp0.vco_mhz);
      boost_ff <= nxt_boost;
      drv_pwr_ff <= sig_det;
      if (!sig_det || state_ff != ST_LOCKED) begin
        out_sel_ff <= OUT_MUTE;
      end else if (reg_out_en_ff[`RCC_BIT_OUT_SEL_EN] && !reg_mux_ff[7]) begin
        out_sel_ff <= OUT_RAW;
      end else begin
        out_sel_ff <= OUT_RETIMED;
      end
    end
  end

  property p_mute;
    @(posedge mclk) disable iff (sys_rst) !sig_det |=> out_sel_ff == OUT_MUTE;
  endproperty
  a_mute: assert property (p_mute) else $error("output not muted without signal");

  property p_hold;
    @(posedge mclk) disable iff (sys_rst) sm_hold |=> ##1 cdr_rst_ff;
  endproperty
  a_hold: assert property (p_hold) else $error("sequencer not held in reset");

  property p_keep;
    @(posedge mclk) disable iff (sys_rst) (sm_hold && !req.wr) |=> $stable(reg_rate_ff);
  endproperty
  a_keep: assert property (p_keep) else $error("registers changed by sequencer reset");

  property p_chrst;
    @(posedge mclk) disable iff (sys_rst) chan_rst |=> reg_rate_ff == `RCC_RST_RATE;
  endproperty
  a_chrst: assert property (p_chrst) else $error("channel reset left register");

  property p_ovr;
    @(posedge mclk) disable iff (sys_rst)
      reg_eq_ovr_ff[`RCC_BIT_EQ_OVR] |=> boost_ff == $past(reg_boost_ovr_ff[3:0]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override boost not applied");

  property p_fixed;
    @(posedge mclk) disable iff (sys_rst)
      (!reg_eq_ovr_ff[`RCC_BIT_EQ_OVR] && cur_div >= 2'h2) |=>
        boost_ff == $past(reg_fixed_ff[3:0]);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed boost not used");

  property p_rb;
    @(posedge mclk) disable iff (sys_rst)
      (req.rd && req.addr == `RCC_OFS_BOOST_RB) |=> rdata_ff == {4'h0, $past(boost_ff)};
  endproperty
  a_rb: assert property (p_rb) else $error("boost readback wrong");

  property p_vco;
    @(posedge mclk) disable iff (sys_rst)
      !$past(sys_rst) |->
        (vco_mhz_ff >= 16'(`RCC_VCO_MIN_MHZ) && vco_mhz_ff <= 16'(`RCC_VCO_MAX_MHZ));
  endproperty
  a_vco: assert property (p_vco) else $error("oscillator out of range");

  property p_raw;
    @(posedge mclk) disable iff (sys_rst)
      (sig_det && state_ff == ST_LOCKED && reg_out_en_ff[5] && !reg_mux_ff[7])
        |=> out_sel_ff == OUT_RAW;
  endproperty
  a_raw: assert property (p_raw) else $error("raw data not selected");

  property p_tap;
    @(posedge mclk) disable iff (sys_rst)
      (tap_valid && !chan_rst) |=> tap_ff[0] == $past(tap_res[4:0]);
  endproperty
  a_tap: assert property (p_tap) else $error("tap result not captured");

  property p_chclr;
    @(posedge mclk) disable iff (sys_rst) chan_rst |=>
      (state_ff == ST_RESET && tap_ff[0] == `RCC_TAP_RESET && reg_mux_ff == `RCC_RST_OUT_MUX);
  endproperty
  a_chclr: assert property (p_chclr) else $error("channel reset incomplete");

  property p_seek;
    @(posedge mclk) disable iff (sys_rst)
      (state_ff == ST_IDLE && sig_det && !sm_hold && !chan_rst) |=> state_ff == ST_SEARCH;
  endproperty
  a_seek: assert property (p_seek) else $error("no lock attempt with signal");

  property p_unlock;
    @(posedge mclk) disable iff (sys_rst) (state_ff != ST_LOCKED) |=> out_sel_ff == OUT_MUTE;
  endproperty
  a_unlock: assert property (p_unlock) else $error("output live without lock");

  property p_div;
    @(posedge mclk) disable iff (sys_rst) (cur_div >= 2'h2) |=> !adapt_en_ff;
  endproperty
  a_div: assert property (p_div) else $error("boost adapted at high divide");
endmodule

//--- tb/rcc_afe_model.sv
// Behavioural model of the analog lane front end seen by the channel control
`timescale 1ns/1ps
module rcc_afe_model #(
  parameter logic [14:0] TAPS = 15'h6a53,
  parameter logic [3:0] ADAPT_VAL = 4'h9
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Scenario controls
  input wire logic present,
  input wire logic [1:0] lock_div,
  // Controls from the channel
  input wire logic [1:0] div_sel,
  input wire logic cdr_rst,
  input wire logic adapt_en,
  // Status to the channel
  output logic sig_det,
  output logic phase_lock,
  output logic adapt_done,
  output logic [3:0] adapt_boost,
  output logic [14:0] tap_res,
  output logic tap_valid
);
  assign adapt_boost = ADAPT_VAL;
  assign tap_res = TAPS;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sig_det <= 1'b0;
      phase_lock <= 1'b0;
      adapt_done <= 1'b0;
      tap_valid <= 1'b0;
    end else begin
      sig_det <= present;
      // Locks only at one chosen divide ratio and never while held in reset
      phase_lock <= present && !cdr_rst && (div_sel == lock_div);
      adapt_done <= phase_lock && adapt_en && !cdr_rst;
      tap_valid <= phase_lock && adapt_en && !cdr_rst && !adapt_done;
    end
  end
endmodule

//--- tb/rcc_channel_tb.sv
// Self-checking bench of the retimer channel control
`timescale 1ns/1ps
module rcc_channel_tb;
  import rcc_pkg::*;
  localparam logic [14:0] TAPS = 15'h6a53;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  rcc_req_t req = '0;
  logic [7:0] rdata_ff;
  logic rvalid_ff, sig_det, phase_lock, adapt_done, tap_valid, present = 1'b0;
  logic [3:0] adapt_boost, boost_ff;
  logic [14:0] tap_res;
  logic cdr_rst_ff, adapt_en_ff, drv_pwr_ff;
  logic [1:0] adapt_mode_ff, div_sel_ff, lock_div = 2'h3;
  logic [15:0] vco_mhz_ff;
  rcc_out_t out_sel_ff;
  int failures = 0;
  int n_tests = 0;
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  rcc_channel rcc_channel_inst (.mclk(mclk), .sys_rst(sys_rst), .req(req),
    .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .sig_det(sig_det),
    .phase_lock(phase_lock), .adapt_done(adapt_done), .adapt_boost(adapt_boost),
    .tap_res(tap_res), .tap_valid(tap_valid), .cdr_rst_ff(cdr_rst_ff),
    .adapt_en_ff(adapt_en_ff), .adapt_mode_ff(adapt_mode_ff), .div_sel_ff(div_sel_ff),
    .vco_mhz_ff(vco_mhz_ff), .boost_ff(boost_ff), .out_sel_ff(out_sel_ff),
    .drv_pwr_ff(drv_pwr_ff));
  rcc_afe_model #(.TAPS(TAPS), .ADAPT_VAL(4'h9)) rcc_afe_model_inst (.mclk(mclk),
    .sys_rst(sys_rst), .present(present), .lock_div(lock_div), .div_sel(div_sel_ff),
    .cdr_rst(cdr_rst_ff), .adapt_en(adapt_en_ff), .sig_det(sig_det),
    .phase_lock(phase_lock), .adapt_done(adapt_done), .adapt_boost(adapt_boost),
    .tap_res(tap_res), .tap_valid(tap_valid));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    req <= '0;
    #1;
    chk({15'h0000, rvalid_ff}, 16'h0001);
    chk({8'h00, rdata_ff}, {8'h00, exp});
  endtask
  task automatic wait_out(input rcc_out_t v);
    int i;
    for (i = 0; i < 6000 && out_sel_ff !== v; i++) begin
      @(posedge mclk);
      #1;
    end
    chk({14'h0000, out_sel_ff}, {14'h0000, v});
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic summarize;
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(25 * 80000);
    failures++;
    summarize;
  end
  initial begin
    int c;
    pause(2);
    chk({15'h0000, cdr_rst_ff}, 16'h0001);
    chk({14'h0000, out_sel_ff}, {14'h0000, OUT_MUTE});
    @(posedge mclk);
    @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h73, 8'h00);
    rd(8'h74, 8'h00);
    rd(8'h75, 8'h00);
    rd(8'h2f, 8'h00);
    rd(8'h1e, 8'h20);
    wr(8'h73, 8'hff);
    rd(8'h73, 8'h00);
    rd(8'hff, 8'h00);
    for (c = 0; c < 16; c++) begin
      wr(8'h2f, {c[3:0], 4'h0});
      rd(8'h2f, {c[3:0], 4'h0});
      pause(3);
      chk({15'h0000, vco_mhz_ff >= 16'd8500 && vco_mhz_ff <= 16'd11300}, 16'h0001);
      if (c == 0 || c == 15) begin
        chk(vco_mhz_ff, 16'd10313);
      end
    end
    wr(8'h2f, 8'h00);
    wr(8'h3a, 8'h07);
    wr(8'h31, 8'h40);
    present <= 1'b1;
    wait_out(OUT_RETIMED);
    chk({14'h0000, div_sel_ff}, 16'h0003);
    chk({12'h000, boost_ff}, 16'h0007);
    chk({15'h0000, adapt_en_ff}, 16'h0000);
    chk({14'h0000, adapt_mode_ff}, 16'h0002);
    wr(8'h0a, 8'h0c);
    pause(3);
    chk({15'h0000, cdr_rst_ff}, 16'h0001);
    chk({14'h0000, out_sel_ff}, {14'h0000, OUT_MUTE});
    rd(8'h3a, 8'h07);
    rd(8'h31, 8'h40);
    lock_div <= 2'h0;
    wr(8'h0a, 8'h08);
    wait_out(OUT_RETIMED);
    chk({14'h0000, div_sel_ff}, 16'h0000);
    pause(4);
    chk({12'h000, boost_ff}, 16'h0009);
    rd(8'h52, 8'h09);
    rd(8'h73, {3'b000, TAPS[4:0]});
    rd(8'h74, {3'b000, TAPS[9:5]});
    rd(8'h75, {3'b000, TAPS[14:10]});
    wr(8'h09, 8'h20);
    wr(8'h1e, 8'h00);
    pause(3);
    chk({14'h0000, out_sel_ff}, {14'h0000, OUT_RAW});
    wr(8'h1e, 8'h80);
    pause(3);
    chk({14'h0000, out_sel_ff}, {14'h0000, OUT_RETIMED});
    wr(8'h03, 8'h05);
    wr(8'h2d, 8'h08);
    pause(3);
    chk({12'h000, boost_ff}, 16'h0005);
    rd(8'h52, 8'h05);
    present <= 1'b0;
    pause(4);
    chk({14'h0000, out_sel_ff}, {14'h0000, OUT_MUTE});
    chk({15'h0000, drv_pwr_ff}, 16'h0000);
    wr(8'h00, 8'h04);
    rd(8'h00, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h2d, 8'h00);
    rd(8'h1e, 8'h20);
    rd(8'h3a, 8'h00);
    rd(8'h73, 8'h00);
    summarize;
  end
endmodule
